// ### pkg/drv_fault_consts.svh
// constants for the octal driver fault controller: offsets, fields, timing
// assumes a 200 MHz system clock and a 32-bit AXI4-Lite register bus
`ifndef DRV_FAULT_CONSTS_SVH
`define DRV_FAULT_CONSTS_SVH

// clock and fault filter timing
`define CLK_PERIOD_NS 5
`define FILTER_TIME_US 100
`define FILTER_CYCLES \
  ((`FILTER_TIME_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TIMER_W 24

// serial frame
`define FRAME_BITS 16
`define IN_OL_LSB 8
`define OUT_TW_BIT 0
`define OUT_PIN_LSB 9
`define OUT_PSF_BIT 15

// register byte offsets
`define ADDR_W 12
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_INPUT 12'h008
`define REG_DRIVE 12'h00c

// reset values
`define CTRL_RESET 1'h0
`define FRAME_RESET 16'h0000

`endif

// ### pkg/drv_fault_pkg.sv
// types shared by the octal driver fault controller and its helpers
// assumes drv_fault_consts.svh is compiled alongside
`include "drv_fault_consts.svh"
package drv_fault_pkg;

  typedef enum logic [1:0] {
    RESP_OKAY = 2'b00,
    RESP_SLVERR = 2'b10
  } resp_t;

  typedef struct packed {
    logic s1;
    logic s2;
  } sync_bit_t;

  typedef struct packed {
    logic [`TIMER_W-1:0] cnt;
    logic hit;
  } timer_state_t;

  typedef struct packed {
    logic cs_prev;
    logic sclk_prev;
    logic [15:0] in_shift;
    logic [15:0] out_shift;
    logic [3:0] bit_cnt;
    logic got_bits;
    logic so;
    logic so_oe;
    logic [15:0] in_reg;
    logic [7:0] oc_latch;
    logic [3:0] tsd_latch;
    logic psf;
    logic [3:0] pin_cap;
    logic [7:0] drv;
  } dev_t;

  typedef struct packed {
    logic force_off;
    logic aw_have;
    logic [`ADDR_W-1:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    resp_t bresp;
    logic arready;
    logic rvalid;
    resp_t rresp;
    logic [31:0] rdata;
  } bus_t;

  typedef struct packed {
    dev_t dev;
    bus_t bus;
  } top_state_t;

endpackage : drv_fault_pkg

// ### src/sync2_bus.sv
// two-flop synchroniser for a bundle of unrelated single-bit inputs
// assumes each bit is independent; no word coherence across bits
`timescale 1ns/10ps
module sync2_bus #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // asynchronous in, synchronised out
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  import drv_fault_pkg::*;

  if (WIDTH < 1) begin : g_bad_width
    $error("sync2_bus: WIDTH must be at least 1");
  end

  for (genvar b = 0; b < WIDTH; b++) begin : g_bit
    sync_bit_t st_q;
    sync_bit_t st_d;
    always_comb begin
      st_d.s1 = din[b];
      st_d.s2 = st_q.s1;
    end
    always_ff @(posedge clk) begin
      if (srst) begin
        st_q <= '0;
      end else begin
        st_q <= st_d;
      end
    end
    assign dout[b] = st_q.s2;
  end

endmodule : sync2_bus

// ### src/fault_timer.sv
// fault filter: reports a condition only after it held for CYCLES clocks
// assumes cond is already synchronous to clk
`timescale 1ns/10ps
`include "drv_fault_consts.svh"
module fault_timer #(
  parameter int CYCLES = `FILTER_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // watched condition and filtered result
  input wire logic cond,
  output logic hit
);
  import drv_fault_pkg::*;

  localparam logic [`TIMER_W-1:0] LAST = `TIMER_W'(CYCLES - 1);

  if (CYCLES < 1 || CYCLES >= (1 << `TIMER_W)) begin : g_bad_cycles
    $error("fault_timer: CYCLES out of range");
  end

  timer_state_t st_q;
  timer_state_t st_d;

  always_comb begin
    st_d = st_q;
    if (!cond) begin
      st_d.cnt = '0;
      st_d.hit = 1'b0;
    end else if (st_q.cnt == LAST) begin
      st_d.hit = 1'b1;
    end else begin
      st_d.cnt = st_q.cnt + `TIMER_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign hit = st_q.hit;

  a_hit_after_count: assert property (@(posedge clk) disable iff (srst)
    $rose(st_q.hit) |-> $past(st_q.cnt) == LAST && $past(cond))
    else $error("filter fired before its full period");
  a_drop_restarts: assert property (@(posedge clk) disable iff (srst)
    !cond |=> st_q.cnt == '0 && !st_q.hit)
    else $error("filter did not restart when condition dropped");

endmodule : fault_timer

// ### src/driver_fault_ctrl.sv
// octal driver control and fault handling behind serial and parallel pins
// assumes all pins and sense comparators are asynchronous to CLK
//
// How it works
// - channels 5-8 switch on when frame bit or parallel pin is set.
// - parallel pin high turns its output on; low leaves it to its frame bit.
// - over-current and open-load count only after 100 us continuously.
// - eight channel timers, each shared by over-current and open-load.
// - warning, shutdown and supply fail have their own timers.
// - open-load only while off, not latched, never blocks turn-on.
// - over-current only while on; latches driver off, no retry.
// - over-current latch clears on valid frame with that enable zero.
// - channels pair as 1-2, 3-4, 5-6, 7-8 for temperature sensing.
// - any pair warning sets output bit zero; outputs stay on, unlatched.
// - shutdown turns both pair drivers off and latches, any command path.
// - shutdown latch clears once cool and frame disables both pair drivers.
// - latches clear the same way by frame; enable low or lockout clears all.
// - chip select falling puts thermal warning on serial out at once.
// - logic supply lockout turns outputs off and clears both registers.
// - load supply fault shuts all channels and latches output bit 15.
// - load supply overvoltage keeps input and output registers intact.
// - load supply recovery restores channels to last commanded state.
// - serial port keeps working during load supply faults.
// - supply fail flag clears on valid frame with supply in range.
// - frame valid only as a multiple of 16 bits; only then latched.
// - frame bits 0-7 switch drivers 1-8, one on, zero off.
// - output bits 9-12 mirror pins, frozen on over-current or shutdown; while any tsd_hit is high they follow the pins.
//
// The AXI4-Lite slave port and the register addresses were decided locally.
`timescale 1ns/10ps
`include "drv_fault_consts.svh"
module driver_fault_ctrl #(
  parameter int FILTER_CYCLES = `FILTER_CYCLES,
  parameter int AUX_FILTER_CYCLES = `FILTER_CYCLES
) (
  // clock and reset
  input wire logic CLK,
  input wire logic SRST,
  // axi4-lite write channels
  input wire logic [`ADDR_W-1:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output drv_fault_pkg::resp_t BRESP,
  output logic BVALID,
  input wire logic BREADY,
  // axi4-lite read channels
  input wire logic [`ADDR_W-1:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output drv_fault_pkg::resp_t RRESP,
  output logic RVALID,
  input wire logic RREADY,
  // serial port pins
  input wire logic CHIP_SELECT_LOW,
  input wire logic SCLK,
  input wire logic SDI,
  output logic SDO,
  output logic SDO_OE,
  // parallel pins for channels 5 to 8, device enable
  input wire logic [3:0] PWM_IN,
  input wire logic ENABLE,
  // supply monitors and fault comparators
  input wire logic UNDERVOLTAGE_LOCKOUT,
  input wire logic LOAD_SUPPLY_UV,
  input wire logic LOAD_SUPPLY_OV,
  input wire logic [7:0] OVERCURRENT,
  input wire logic [7:0] OPEN_LOAD,
  input wire logic [3:0] THERMAL_WARN_PAIR,
  input wire logic [3:0] THERMAL_SHUT_PAIR,
  // output stage commands
  output logic [7:0] DRIVE_ON
);
  import drv_fault_pkg::*;

  localparam int SYNC_W = 35;

  if (FILTER_CYCLES < 1 || AUX_FILTER_CYCLES < 1) begin : g_bad_filter
    $error("driver_fault_ctrl: filter periods must be at least one cycle");
  end

  top_state_t st_q;
  top_state_t st_d;

  logic [SYNC_W-1:0] raw;
  logic [SYNC_W-1:0] syn;
  logic cs_n_s, sclk_s, sdi_s, en_s, lock_s, ls_uv_s, ls_ov_s;
  logic [3:0] pin_s, twp_s, tsp_s;
  logic [7:0] oc_s, ol_s;

  assign raw = {CHIP_SELECT_LOW, SCLK, SDI, PWM_IN, ENABLE,
                UNDERVOLTAGE_LOCKOUT, LOAD_SUPPLY_UV, LOAD_SUPPLY_OV,
                OVERCURRENT, OPEN_LOAD, THERMAL_WARN_PAIR, THERMAL_SHUT_PAIR};
  assign {cs_n_s, sclk_s, sdi_s, pin_s, en_s, lock_s, ls_uv_s, ls_ov_s,
          oc_s, ol_s, twp_s, tsp_s} = syn;

  sync2_bus #(.WIDTH(SYNC_W)) u_sync (
    .clk(CLK),
    .srst(SRST),
    .din(raw),
    .dout(syn)
  );

  // logic reset: enable pin low or logic supply lockout
  logic lrst;
  logic [7:0] cmd_on, ch_cond, ch_hit, oc_set, ol_live, status_bits;
  logic [3:0] tw_hit, tsd_hit, mirror;
  logic supply_hit, thermal_warning_flag, frame_ok, cs_fall, cs_rise;
  logic sclk_rise, sclk_fall;
  logic [15:0] out_word;

  assign lrst = ~en_s | lock_s;
  assign cmd_on = st_q.dev.in_reg[7:0] | {pin_s, 4'h0};

  // one timer per channel, shared by both channel faults
  for (genvar c = 0; c < 8; c++) begin : g_chan
    assign ch_cond[c] = (oc_s[c] & st_q.dev.drv[c]) |
                        (ol_s[c] & ~cmd_on[c] & ~supply_hit &
                         st_q.dev.in_reg[`IN_OL_LSB + c]);
    fault_timer #(.CYCLES(FILTER_CYCLES)) u_ch_timer (
      .clk(CLK),
      .srst(SRST),
      .cond(ch_cond[c]),
      .hit(ch_hit[c])
    );
  end

  // one warning and one shutdown timer per thermal pair
  for (genvar p = 0; p < 4; p++) begin : g_pair
    fault_timer #(.CYCLES(AUX_FILTER_CYCLES)) u_warn_timer (
      .clk(CLK),
      .srst(SRST),
      .cond(twp_s[p]),
      .hit(tw_hit[p])
    );
    fault_timer #(.CYCLES(AUX_FILTER_CYCLES)) u_shut_timer (
      .clk(CLK),
      .srst(SRST),
      .cond(tsp_s[p]),
      .hit(tsd_hit[p])
    );
  end

  fault_timer #(.CYCLES(AUX_FILTER_CYCLES)) u_supply_timer (
    .clk(CLK),
    .srst(SRST),
    .cond(ls_uv_s | ls_ov_s),
    .hit(supply_hit)
  );

  assign thermal_warning_flag = |tw_hit;
  assign oc_set = ch_hit & st_q.dev.drv;
  assign ol_live = ch_hit & ~cmd_on;
  assign cs_fall = st_q.dev.cs_prev & ~cs_n_s;
  assign cs_rise = ~st_q.dev.cs_prev & cs_n_s;
  assign sclk_rise = ~st_q.dev.sclk_prev & sclk_s & ~cs_n_s;
  assign sclk_fall = st_q.dev.sclk_prev & ~sclk_s & ~cs_n_s;
  // whole 16-bit multiples only; stray bits void the frame
  assign frame_ok = cs_rise & st_q.dev.got_bits &
                    (st_q.dev.bit_cnt == 4'h0);
  assign mirror = ((|st_q.dev.oc_latch) | (|st_q.dev.tsd_latch)) ?
                  st_q.dev.pin_cap : pin_s;

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      status_bits[i] = st_q.dev.oc_latch[i] | st_q.dev.tsd_latch[i / 2] |
                       ol_live[i];
    end
  end

  assign out_word = {st_q.dev.psf, 2'b00, mirror, status_bits,
                     thermal_warning_flag};

  always_comb begin
    st_d = st_q;
    st_d.dev.cs_prev = cs_n_s;
    st_d.dev.sclk_prev = sclk_s;

    // serial port stays live through load supply faults
    if (cs_fall) begin
      st_d.dev.out_shift = out_word;
      st_d.dev.so = thermal_warning_flag;
      st_d.dev.so_oe = 1'b1;
      st_d.dev.bit_cnt = 4'h0;
      st_d.dev.got_bits = 1'b0;
    end else if (cs_rise) begin
      st_d.dev.so = 1'b0;
      st_d.dev.so_oe = 1'b0;
    end else if (sclk_rise) begin
      st_d.dev.in_shift = {st_q.dev.in_shift[14:0], sdi_s};
      st_d.dev.bit_cnt = st_q.dev.bit_cnt + 4'h1;
      st_d.dev.got_bits = 1'b1;
    end else if (sclk_fall) begin
      // last received bit follows for daisy chaining
      st_d.dev.so = st_q.dev.out_shift[15];
      st_d.dev.out_shift = {st_q.dev.out_shift[14:0], st_q.dev.in_shift[0]};
    end
    if (frame_ok) begin
      st_d.dev.in_reg = st_q.dev.in_shift;
    end

    // latches: a set in the clearing cycle wins
    for (int i = 0; i < 8; i++) begin
      if (frame_ok && !st_q.dev.in_shift[i]) begin
        st_d.dev.oc_latch[i] = 1'b0;
      end
      if (oc_set[i]) begin
        st_d.dev.oc_latch[i] = 1'b1;
      end
    end
    for (int p = 0; p < 4; p++) begin
      if (frame_ok && !tsd_hit[p] && !st_q.dev.in_shift[2 * p] &&
          !st_q.dev.in_shift[2 * p + 1]) begin
        st_d.dev.tsd_latch[p] = 1'b0;
      end
      if (tsd_hit[p]) begin
        st_d.dev.tsd_latch[p] = 1'b1;
      end
    end
    if (frame_ok && !supply_hit) begin
      st_d.dev.psf = 1'b0;
    end
    if (supply_hit) begin
      st_d.dev.psf = 1'b1;
    end
    if ((|oc_set) || (|tsd_hit)) begin
      st_d.dev.pin_cap = pin_s;
    end

    // registers kept through supply faults, so recovery restores commands
    for (int i = 0; i < 8; i++) begin
      st_d.dev.drv[i] = cmd_on[i] & ~st_q.dev.oc_latch[i] &
                        ~st_q.dev.tsd_latch[i / 2] & ~supply_hit &
                        ~st_q.bus.force_off;
    end

    // axi4-lite write side
    if (st_q.bus.awready && AWVALID) begin
      st_d.bus.aw_have = 1'b1;
      st_d.bus.aw_addr = AWADDR;
    end
    if (st_q.bus.wready && WVALID) begin
      st_d.bus.w_have = 1'b1;
      st_d.bus.w_data = WDATA;
      st_d.bus.w_strb = WSTRB;
    end
    if (st_q.bus.aw_have && st_q.bus.w_have && !st_q.bus.bvalid) begin
      st_d.bus.aw_have = 1'b0;
      st_d.bus.w_have = 1'b0;
      st_d.bus.bvalid = 1'b1;
      if ({st_q.bus.aw_addr[`ADDR_W-1:2], 2'b00} == `REG_CTRL) begin
        st_d.bus.bresp = RESP_OKAY;
        if (st_q.bus.w_strb[0]) begin
          st_d.bus.force_off = st_q.bus.w_data[0];
        end
      end else begin
        st_d.bus.bresp = RESP_SLVERR;
      end
    end
    if (st_q.bus.bvalid && BREADY) begin
      st_d.bus.bvalid = 1'b0;
    end
    st_d.bus.awready = ~st_d.bus.aw_have & ~st_d.bus.bvalid;
    st_d.bus.wready = ~st_d.bus.w_have & ~st_d.bus.bvalid;

    // axi4-lite read side
    if (st_q.bus.rvalid && RREADY) begin
      st_d.bus.rvalid = 1'b0;
    end
    if (st_q.bus.arready && ARVALID) begin
      st_d.bus.rvalid = 1'b1;
      st_d.bus.rresp = RESP_OKAY;
      if ({ARADDR[`ADDR_W-1:2], 2'b00} == `REG_CTRL) begin
        st_d.bus.rdata = {31'h0, st_q.bus.force_off};
      end else if ({ARADDR[`ADDR_W-1:2], 2'b00} == `REG_STATUS) begin
        st_d.bus.rdata = {16'h0, out_word};
      end else if ({ARADDR[`ADDR_W-1:2], 2'b00} == `REG_INPUT) begin
        st_d.bus.rdata = {16'h0, st_q.dev.in_reg};
      end else if ({ARADDR[`ADDR_W-1:2], 2'b00} == `REG_DRIVE) begin
        st_d.bus.rdata = {19'h0, supply_hit, st_q.dev.tsd_latch,
                          st_q.dev.drv};
      end else begin
        st_d.bus.rdata = 32'h0;
        st_d.bus.rresp = RESP_SLVERR;
      end
    end
    st_d.bus.arready = ~st_d.bus.rvalid;

    // enable low or lockout: outputs off, both registers and latches cleared
    if (lrst) begin
      st_d.dev = '0;
      st_d.dev.cs_prev = cs_n_s;
      st_d.dev.sclk_prev = sclk_s;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      st_q <= '0;
      // cs_prev keeps the synchroniser's reset level: no false select edge
      st_q.dev.in_reg <= `FRAME_RESET;
      st_q.bus.force_off <= `CTRL_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign DRIVE_ON = st_q.dev.drv;
  assign SDO = st_q.dev.so;
  assign SDO_OE = st_q.dev.so_oe;
  assign AWREADY = st_q.bus.awready;
  assign WREADY = st_q.bus.wready;
  assign BVALID = st_q.bus.bvalid;
  assign BRESP = st_q.bus.bresp;
  assign ARREADY = st_q.bus.arready;
  assign RVALID = st_q.bus.rvalid;
  assign RRESP = st_q.bus.rresp;
  assign RDATA = st_q.bus.rdata;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  a_or_pin_on: assert property (
    pin_s[0] && !st_q.dev.oc_latch[4] && !st_q.dev.tsd_latch[2] &&
    !supply_hit && !st_q.bus.force_off && !lrst |=> DRIVE_ON[4])
    else $error("parallel pin did not turn channel 5 on");
  a_oc_only_on: assert property (
    $rose(st_q.dev.oc_latch[0]) |-> $past(st_q.dev.drv[0]))
    else $error("over-current latched while driver was off");
  a_oc_latched_off: assert property (
    st_q.dev.oc_latch[0] |=> !DRIVE_ON[0])
    else $error("driver on despite latched over-current");
  a_oc_clear_cause: assert property (
    $fell(st_q.dev.oc_latch[0]) |->
      $past(lrst || (frame_ok && !st_q.dev.in_shift[0])))
    else $error("over-current latch cleared without a disabling frame");
  a_tsd_pair_off: assert property (
    st_q.dev.tsd_latch[1] |=> !DRIVE_ON[2] && !DRIVE_ON[3])
    else $error("pair not off during thermal shutdown");
  a_tsd_clear_cause: assert property (
    $fell(st_q.dev.tsd_latch[1]) |-> $past(lrst || (frame_ok &&
      !tsd_hit[1] && !st_q.dev.in_shift[2] && !st_q.dev.in_shift[3])))
    else $error("shutdown latch cleared without cooling and frame");
  a_warn_on_select: assert property (
    cs_fall |=> SDO_OE && SDO == $past(thermal_warning_flag))
    else $error("warning not shown on serial out at select");
  a_supply_shut: assert property (
    supply_hit |=> st_q.dev.psf && DRIVE_ON == 8'h00)
    else $error("supply fault did not latch flag and stop drivers");
  a_psf_clear_cause: assert property (
    $fell(st_q.dev.psf) |-> $past(lrst || (frame_ok && !supply_hit)))
    else $error("supply fail flag cleared without frame in range");
  a_lockout_clears: assert property (
    lrst |=> DRIVE_ON == 8'h00 && st_q.dev.in_reg == 16'h0000)
    else $error("lockout left outputs or input register set");

  c_frame_taken: cover property (frame_ok);
  c_oc_latch: cover property ($rose(st_q.dev.oc_latch[0]));
  c_tsd_latch: cover property ($rose(st_q.dev.tsd_latch[1]));
  c_warn_select: cover property (cs_fall && thermal_warning_flag);

endmodule : driver_fault_ctrl

// ### sim/spi_host_model.sv
// host side model: serial master and the four parallel control pins
// assumes the device samples these pins with its own faster clock
`timescale 1ns/10ps
module spi_host_model (
  // serial pins
  output logic cs_low,
  output logic sclk,
  output logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe,
  // parallel pins for channels 5 to 8
  output logic [3:0] pwm
);
  // idle levels follow the pin pull resistors
  initial begin
    cs_low = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
    pwm = 4'h0;
  end

  // settle time so the device has resynced the pins before a frame
  task automatic pins(input logic [3:0] p);
    // step off the clock edge so the device never races the pin change
    #1 pwm = p;
    #100;
  endtask : pins

  // nb bits msb first, 160 ns period, sclk low when select rises
  task automatic xfer(input logic [31:0] v, input int nb,
                      output logic warn, output logic [15:0] rx);
    rx = 16'h0;
    // a released line reads as the inverse, so a missing enable shows up
    #1 cs_low = 1'b0;
    #40 warn = sdo_oe ? sdo : ~sdo;
    for (int i = nb - 1; i >= 0; i--) begin
      sdi = v[i];
      #40 sclk = 1'b1;
      #80 sclk = 1'b0;
      #40 rx = {rx[14:0], sdo_oe ? sdo : ~sdo};
    end
    sdi = 1'b0;
    #40 cs_low = 1'b1;
    #200;
  endtask : xfer
endmodule : spi_host_model

// ### sim/driver_fault_ctrl_test.sv
// self-checking bench for the octal driver fault controller
// assumes the host model drives the serial and parallel pins
`timescale 1ns/10ps
`include "drv_fault_consts.svh"
module driver_fault_ctrl_test;
  import drv_fault_pkg::*;
  logic clk, srst, enable, undervoltage_lockout, ls_uv, ls_ov;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [`ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb, pwm, warn_p, shut_p;
  logic [7:0] oc, ol, drive_on;
  logic cs_low, sclk, sdi, sdo, oe, w;
  logic [15:0] rx;
  resp_t bresp, rresp, r;
  int failures, checked;

  // short filters keep the fault scenarios brief
  driver_fault_ctrl #(.FILTER_CYCLES(8), .AUX_FILTER_CYCLES(4)) i_dut (
    .CLK(clk), .SRST(srst), .AWADDR(awaddr), .AWVALID(awvalid),
    .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid),
    .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
    .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
    .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
    .CHIP_SELECT_LOW(cs_low), .SCLK(sclk), .SDI(sdi), .SDO(sdo),
    .SDO_OE(oe), .PWM_IN(pwm), .ENABLE(enable),
    .UNDERVOLTAGE_LOCKOUT(undervoltage_lockout), .LOAD_SUPPLY_UV(ls_uv),
    .LOAD_SUPPLY_OV(ls_ov), .OVERCURRENT(oc), .OPEN_LOAD(ol),
    .THERMAL_WARN_PAIR(warn_p), .THERMAL_SHUT_PAIR(shut_p),
    .DRIVE_ON(drive_on));

  spi_host_model i_host (.cs_low(cs_low), .sclk(sclk), .sdi(sdi),
    .sdo(sdo), .sdo_oe(oe), .pwm(pwm));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic summarize();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : summarize

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic hang(input string nm);
    failures++;
    $display("[FAIL] %s expected answer seen none", nm);
    summarize();
  endtask : hang

  task automatic axw(input logic [11:0] a, input logic [31:0] v);
    bit ok;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    {awvalid, wvalid, bready} <= 3'b111;
    for (int n = 0; !ok && n < 100; n++) begin
      @(posedge clk);
      if (awready && awvalid) awvalid <= 1'b0;
      if (wready && wvalid) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        ok = 1'b1;
      end
    end
    if (!ok) hang("write");
  endtask : axw

  task automatic axr(input logic [11:0] a, output logic [31:0] v);
    bit ok;
    @(posedge clk);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    for (int n = 0; !ok && n < 100; n++) begin
      @(posedge clk);
      if (arready && arvalid) arvalid <= 1'b0;
      if (rvalid) begin
        v = rdata;
        r = rresp;
        rready <= 1'b0;
        ok = 1'b1;
      end
    end
    if (!ok) hang("read");
  endtask : axr

  // bounded wait for the output stage to reach a pattern
  task automatic wait_drv(input logic [7:0] e);
    @(posedge clk);
    for (int n = 0; drive_on !== e && n < 200; n++) @(posedge clk);
    chk("drive_on", {24'h0, e}, {24'h0, drive_on});
    if (drive_on !== e) summarize();
  endtask : wait_drv

  task automatic sf(input logic [31:0] v, input int nb = 16);
    i_host.xfer(v, nb, w, rx);
  endtask : sf

  initial begin
    {srst, enable, undervoltage_lockout, ls_uv, ls_ov} = 5'b11000;
    {awvalid, wvalid, bready, arvalid, rready} = 5'b0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    {oc, ol, warn_p, shut_p} = '0;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    repeat (5) @(posedge clk);
    chk("drive_rst", 32'h0, {24'h0, drive_on});
    axr(`REG_CTRL, d);
    chk("ctrl_rst", 32'h0, d);
    axw(`REG_STATUS, 32'h1);
    chk("ro_resp", {30'h0, RESP_SLVERR}, {30'h0, r});
    axr(12'h100, d);
    chk("unmapped", {30'h0, RESP_SLVERR}, {30'h0, r});
    $display("test registers done");
    sf(32'h00a5);
    wait_drv(8'ha5);
    axr(`REG_INPUT, d);
    chk("input_reg", 32'h00a5, d);
    sf(32'h005a, 15);
    repeat (30) @(posedge clk);
    chk("short_frame", 32'ha5, {24'h0, drive_on});
    sf(32'h0011_0022, 32);
    wait_drv(8'h22);
    axw(`REG_CTRL, 32'h1);
    chk("ctrl_resp", {30'h0, RESP_OKAY}, {30'h0, r});
    wait_drv(8'h00);
    axr(`REG_CTRL, d);
    chk("ctrl_rw", 32'h1, d);
    axw(`REG_CTRL, 32'h0);
    wait_drv(8'h22);
    wstrb <= 4'he;
    axw(`REG_CTRL, 32'h1);
    wstrb <= 4'hf;
    axr(`REG_CTRL, d);
    chk("ctrl_strb", 32'h0, d);
    $display("test frames done");
    i_host.pins(4'hb);
    sf(32'h0010);
    chk("pin_mirror", 32'h1600, {16'h0, rx});
    wait_drv(8'hb0);
    i_host.pins(4'h0);
    wait_drv(8'h10);
    $display("test parallel done");
    sf(32'h0001);
    i_host.pins(4'h4);
    wait_drv(8'h41);
    repeat (2) begin
      oc <= 8'h01;
      repeat (6) @(posedge clk);
      oc <= 8'h00;
      repeat (2) @(posedge clk);
    end
    repeat (20) @(posedge clk);
    chk("oc_glitch", 32'h41, {24'h0, drive_on});
    oc <= 8'h01;
    wait_drv(8'h40);
    oc <= 8'h00;
    i_host.pins(4'h0);
    sf(32'h0001);
    chk("oc_status", 32'h0802, {16'h0, rx});
    axr(`REG_STATUS, d);
    chk("status_reg", 32'h0802, d);
    repeat (30) @(posedge clk);
    chk("oc_no_retry", 32'h0, {24'h0, drive_on});
    sf(32'h0000);
    sf(32'h0001);
    chk("oc_cleared", 32'h0, {16'h0, rx});
    wait_drv(8'h01);
    $display("test over_current done");
    sf(32'h0100);
    @(posedge clk);
    ol <= 8'h01;
    repeat (30) @(posedge clk);
    sf(32'h0101);
    chk("ol_status", 32'h0002, {16'h0, rx});
    wait_drv(8'h01);
    sf(32'h0101);
    chk("ol_when_on", 32'h0, {16'h0, rx});
    @(posedge clk);
    ol <= 8'h00;
    $display("test open_load done");
    sf(32'h00ff);
    wait_drv(8'hff);
    shut_p <= 4'h2;
    wait_drv(8'hf3);
    axr(`REG_DRIVE, d);
    chk("drive_reg", 32'h02f3, d);
    sf(32'h00ff);
    chk("tsd_status", 32'h0018, {16'h0, rx});
    @(posedge clk);
    shut_p <= 4'h0;
    repeat (20) @(posedge clk);
    sf(32'h00f7);
    repeat (30) @(posedge clk);
    chk("tsd_hold", 32'hf3, {24'h0, drive_on});
    sf(32'h00f3);
    sf(32'h00ff);
    wait_drv(8'hff);
    @(posedge clk);
    warn_p <= 4'h8;
    repeat (20) @(posedge clk);
    sf(32'h00ff);
    chk("warn_sdo", 32'h1, {31'h0, w});
    chk("warn_bit", 32'h0001, {16'h0, rx});
    chk("warn_on", 32'hff, {24'h0, drive_on});
    @(posedge clk);
    warn_p <= 4'h0;
    repeat (20) @(posedge clk);
    sf(32'h00ff);
    chk("warn_gone", 32'h0, {31'h0, w});
    chk("oe_idle", 32'h0, {31'h0, oe});
    $display("test thermal done");
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      {ls_ov, ls_uv} <= 2'b01 << k;
      wait_drv(8'h00);
      sf(32'h000f);
      chk("psf_set", 32'h8000, {16'h0, rx});
      axr(`REG_INPUT, d);
      chk("psf_keep", 32'h000f, d);
      @(posedge clk);
      {ls_ov, ls_uv} <= 2'b00;
      wait_drv(8'h0f);
      sf(32'h00ff);
      chk("psf_hold", 32'h8000, {16'h0, rx});
      sf(32'h00ff);
      chk("psf_clear", 32'h0, {16'h0, rx});
    end
    $display("test supply done");
    @(posedge clk);
    undervoltage_lockout <= 1'b1;
    wait_drv(8'h00);
    undervoltage_lockout <= 1'b0;
    repeat (10) @(posedge clk);
    axr(`REG_INPUT, d);
    chk("undervoltage_lockout_clear", 32'h0, d);
    sf(32'h0001);
    wait_drv(8'h01);
    oc <= 8'h01;
    wait_drv(8'h00);
    oc <= 8'h00;
    enable <= 1'b0;
    repeat (10) @(posedge clk);
    enable <= 1'b1;
    repeat (10) @(posedge clk);
    sf(32'h0001);
    chk("en_clear", 32'h0, {16'h0, rx});
    wait_drv(8'h01);
    $display("test lockout done");
    summarize();
  end
endmodule : driver_fault_ctrl_test
